// file: phsc_pkg.sv
package phsc_pkg;

  // stacks, endpoints and lanes of one controller
  localparam int NSTK  = 3;
  localparam int NEP   = 4;
  localparam int NLANE = 16;

  // queue resources
  localparam logic [7:0] RD_MAX_WIDE = 8'h80;
  localparam logic [7:0] RD_MAX      = 8'h40;
  localparam logic [5:0] WR_MAX      = 6'h20;
  localparam logic [4:0] MM_ST_MAX   = 5'h10;
  localparam logic [4:0] MM_LD_MAX   = 5'h10;

  // outbound address windows
  localparam logic [31:0] WIN0_BASE = 32'h8000_0000;
  localparam logic [31:0] WIN0_MASK = 32'hF000_0000;
  localparam logic [31:0] WIN1_BASE = 32'hA000_0000;
  localparam logic [31:0] WIN1_MASK = 32'hF000_0000;

  // interrupt vector limits per stack width
  localparam logic [12:0] MSI_WIDE   = 13'h1000;
  localparam logic [12:0] MSI_NARROW = 13'h0800;

  // nest rate and slowed link rates, in MHz
  localparam int NEST_MHZ = 2000;
  localparam int G1_MHZ   = 250;
  localparam int G2_MHZ   = 500;
  localparam int G3_MHZ   = 1000;
  localparam logic [3:0] DIV_G1 = 4'(NEST_MHZ / G1_MHZ);
  localparam logic [3:0] DIV_G2 = 4'(NEST_MHZ / G2_MHZ);
  localparam logic [3:0] DIV_G3 = 4'(NEST_MHZ / G3_MHZ);
  localparam logic [3:0] DIV_G4 = 4'h1;

  // buffering
  localparam int FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    MODE_X16   = 2'b00,
    MODE_2X8   = 2'b01,
    MODE_X8X4  = 2'b10
  } phsc_mode_e;

  typedef enum logic [1:0] {
    K_READ  = 2'b00,
    K_WRITE = 2'b01,
    K_ATOM  = 2'b10,
    K_MSI   = 2'b11
  } phsc_kind_e;

  typedef struct packed {
    logic [1:0]  stk;
    logic [1:0]  ep;
    phsc_kind_e  kind;
    logic [11:0] msi;
    logic [7:0]  tag;
  } phsc_inb_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [1:0]  stk;
    logic        store;
    logic        atomic;
  } phsc_mmio_s;

  typedef struct packed {
    logic [1:0] stk;
    logic       rd;
    logic       bad;
  } phsc_cpl_s;

  typedef struct packed {
    logic [1:0] stk;
    logic [1:0] ep;
    logic       whole;
  } phsc_err_s;

endpackage

// file: phsc_top.sv
`timescale 1ns/1ps
`default_nettype none

module phsc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  // fill side
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  // drain side
  output logic              rd_valid,
  output logic [W-1:0]      rd_data,
  input  wire logic         rd_ready
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
    logic                rdy;
  } phsc_fst_s;

  phsc_fst_s st_ff;
  phsc_fst_s nxt_st;
  logic      push;
  logic      pop;

  assign wr_ready = st_ff.rdy;
  assign rd_valid = st_ff.cnt != '0;
  assign rd_data  = st_ff.mem[st_ff.rp];
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;

  always_comb
  begin
    nxt_st = st_ff;
    if (push)
    begin
      nxt_st.mem[st_ff.wp] = wr_data;
      nxt_st.wp = st_ff.wp + 1'b1;
    end
    if (pop)
      nxt_st.rp = st_ff.rp + 1'b1;
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    nxt_st.rdy = nxt_st.cnt != (AW+1)'(D);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_ff.mem <= '0;
      st_ff.wp  <= '0;
      st_ff.rp  <= '0;
      st_ff.cnt <= '0;
      st_ff.rdy <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end
endmodule

module phsc_top #(
  parameter int CTRL_ID = 2
) (
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               rst,
  // inbound requests from the stacks
  input  wire logic               in_valid,
  input  wire phsc_pkg::phsc_inb_s in_req,
  output logic                    in_ready,
  output logic                    in_drop,
  // requests to the fabric
  output logic                    fab_valid,
  output phsc_pkg::phsc_inb_s     fab_req,
  input  wire logic               fab_ready,
  // fabric completions and answers to stacks
  input  wire logic               cpl_valid,
  input  wire phsc_pkg::phsc_cpl_s cpl,
  output logic                    rsp_valid,
  output logic [1:0]              rsp_stk,
  output logic                    rsp_bad,
  // outbound MMIO
  input  wire logic               mm_valid,
  input  wire phsc_pkg::phsc_mmio_s mm_req,
  output logic                    mm_ok,
  output logic                    mm_refuse,
  output logic                    mm_atomic,
  input  wire logic               mm_done,
  input  wire logic               mm_done_store,
  // errors and recovery
  input  wire logic               err_valid,
  input  wire phsc_pkg::phsc_err_s err,
  input  wire logic               ep_clr_valid,
  input  wire logic [3:0]         ep_clr,
  input  wire logic [2:0]         stk_reset,
  output logic [2:0]              frozen,
  output logic [11:0]             ep_blocked,
  output logic                    par_err,
  // lane configuration and link rate
  input  wire logic               cfg_load,
  input  wire phsc_pkg::phsc_mode_e cfg_mode,
  input  wire logic [2:0]         lane_rev,
  input  wire logic [2:0][1:0]    link_gen,
  output logic [2:0]              stack_act,
  output logic                    cfg_err,
  output logic [15:0][3:0]        lane_map,
  output logic [2:0][3:0]         link_div
);
  localparam logic [7:0] RD_LIM =
    (CTRL_ID == 0) ? phsc_pkg::RD_MAX_WIDE : phsc_pkg::RD_MAX;
  localparam phsc_pkg::phsc_mode_e MODE_RST =
    (CTRL_ID == 1) ? phsc_pkg::MODE_2X8 : phsc_pkg::MODE_X16;

  typedef struct packed {
    logic                 fab_v;
    phsc_pkg::phsc_inb_s  fab_q;
    logic                 drop;
    logic                 rsp_v;
    logic [1:0]           rsp_stk;
    logic                 rsp_bad;
    logic                 mm_ok;
    logic                 mm_ref;
    logic                 mm_atom;
    logic [7:0]           rd_cnt;
    logic [5:0]           wr_cnt;
    logic [4:0]           st_cnt;
    logic [4:0]           ld_cnt;
    logic [2:0]           frz;
    logic [11:0]          blk;
    logic                 prot;
    phsc_pkg::phsc_mode_e mode;
    logic [2:0]           act;
    logic                 cfg_err;
    logic [15:0][3:0]     lmap;
    logic [2:0][3:0]      ldiv;
    logic                 par_err;
  } phsc_st_s;

  phsc_st_s             st_ff;
  phsc_st_s             nxt_st;
  logic                 h_v;
  logic [$bits(phsc_pkg::phsc_inb_s):0] h_w;
  phsc_pkg::phsc_inb_s  h;
  logic                 h_pop;

  // shared queue buffer; its far side is the adapter boundary
  phsc_fifo #(
    .W ($bits(phsc_pkg::phsc_inb_s) + 1),
    .D (phsc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .wr_valid (in_valid),
    .wr_data  ({^in_req, in_req}),
    .wr_ready (in_ready),
    .rd_valid (h_v),
    .rd_data  (h_w),
    .rd_ready (h_pop)
  );

  assign h = h_w[$bits(phsc_pkg::phsc_inb_s)-1:0];

  function automatic logic [2:0] act_of(phsc_pkg::phsc_mode_e m);
    unique case (m)
      phsc_pkg::MODE_X16:  act_of = 3'h1;
      phsc_pkg::MODE_2X8:  act_of = 3'h3;
      phsc_pkg::MODE_X8X4: act_of = 3'h7;
      default:             act_of = 3'h0;
    endcase
  endfunction

  function automatic logic mode_ok(phsc_pkg::phsc_mode_e m);
    unique case (CTRL_ID)
      0:       mode_ok = m == phsc_pkg::MODE_X16;
      1:       mode_ok = m == phsc_pkg::MODE_2X8;
      default: mode_ok = act_of(m) != 3'h0;
    endcase
  endfunction

  always_comb
  begin
    logic       refuse;
    logic       credit;
    logic       out_free;
    logic       narrow;
    logic [3:0] ep_ix;
    logic       rd_inc;
    logic       wr_inc;
    logic       rd_dec;
    logic       wr_dec;
    logic [1:0] s;
    logic       hit;
    logic       mm_take;
    logic [4:0] base;
    logic [4:0] size;
    logic [3:0] li;
    refuse   = 1'b0;
    credit   = 1'b0;
    out_free = 1'b0;
    narrow   = 1'b0;
    ep_ix    = 4'h0;
    rd_inc   = 1'b0;
    wr_inc   = 1'b0;
    rd_dec   = 1'b0;
    wr_dec   = 1'b0;
    s        = 2'h0;
    hit      = 1'b0;
    mm_take  = 1'b0;
    base     = 5'h0;
    size     = 5'h0;
    li       = 4'h0;
    nxt_st   = st_ff;
    nxt_st.drop    = 1'b0;
    nxt_st.rsp_v   = 1'b0;
    nxt_st.mm_ok   = 1'b0;
    nxt_st.mm_ref  = 1'b0;
    nxt_st.mm_atom = 1'b0;
    h_pop    = 1'b0;

    // inbound head: admit, refuse or stall
    if (st_ff.fab_v && fab_ready)
      nxt_st.fab_v = 1'b0;
    out_free = !st_ff.fab_v || fab_ready;
    ep_ix  = {h.stk, h.ep};
    narrow = st_ff.mode == phsc_pkg::MODE_X8X4 && h.stk != 2'h0;
    refuse = st_ff.frz[h.stk] || !st_ff.act[h.stk];
    if (st_ff.blk[ep_ix])
      refuse = 1'b1;
    if (h.kind == phsc_pkg::K_MSI && 13'(h.msi) >=
        (narrow ? phsc_pkg::MSI_NARROW : phsc_pkg::MSI_WIDE))
      refuse = 1'b1;
    if (^h_w)
      refuse = 1'b1;
    if (h.kind == phsc_pkg::K_READ)
      credit = st_ff.rd_cnt < RD_LIM;
    else
      credit = st_ff.wr_cnt < phsc_pkg::WR_MAX;
    if (h_v && refuse)
    begin
      h_pop = 1'b1;
      nxt_st.drop = 1'b1;
      if (^h_w)
        nxt_st.par_err = 1'b1;
    end
    else if (h_v && credit && out_free)
    begin
      h_pop = 1'b1;
      nxt_st.fab_v = 1'b1;
      nxt_st.fab_q = h;
      rd_inc = h.kind == phsc_pkg::K_READ;
      wr_inc = h.kind != phsc_pkg::K_READ;
    end

    // completions run to the end even when frozen
    if (cpl_valid)
    begin
      nxt_st.rsp_v   = 1'b1;
      nxt_st.rsp_stk = cpl.stk;
      nxt_st.rsp_bad = cpl.bad || st_ff.frz[cpl.stk];
      rd_dec = cpl.rd && st_ff.rd_cnt != 8'h0;
      wr_dec = !cpl.rd && st_ff.wr_cnt != 6'h0;
    end
    nxt_st.rd_cnt = st_ff.rd_cnt + 8'(rd_inc) - 8'(rd_dec);
    nxt_st.wr_cnt = st_ff.wr_cnt + 6'(wr_inc) - 6'(wr_dec);

    // outbound MMIO and atomic results
    hit = ((mm_req.addr & phsc_pkg::WIN0_MASK) == phsc_pkg::WIN0_BASE) ||
          ((mm_req.addr & phsc_pkg::WIN1_MASK) == phsc_pkg::WIN1_BASE);
    s = mm_req.stk;
    if (mm_valid)
    begin
      mm_take = (hit || mm_req.atomic) && st_ff.act[s] && !st_ff.frz[s] &&
                (mm_req.store || mm_req.atomic ?
                 st_ff.st_cnt < phsc_pkg::MM_ST_MAX :
                 st_ff.ld_cnt < phsc_pkg::MM_LD_MAX);
      nxt_st.mm_ok   = mm_take;
      nxt_st.mm_ref  = !mm_take;
      nxt_st.mm_atom = mm_take && mm_req.atomic;
    end
    nxt_st.st_cnt = st_ff.st_cnt
      + 5'(mm_take && (mm_req.store || mm_req.atomic))
      - 5'(mm_done && mm_done_store && st_ff.st_cnt != 5'h0);
    nxt_st.ld_cnt = st_ff.ld_cnt
      + 5'(mm_take && !mm_req.store && !mm_req.atomic)
      - 5'(mm_done && !mm_done_store && st_ff.ld_cnt != 5'h0);

    // endpoint blocking and stack freeze; set wins over clear
    if (ep_clr_valid)
      nxt_st.blk[ep_clr] = 1'b0;
    for (int i = 0; i < phsc_pkg::NSTK; i++)
      if (stk_reset[i])
      begin
        nxt_st.frz[i] = 1'b0;
        nxt_st.blk[i*phsc_pkg::NEP +: phsc_pkg::NEP] = '0;
      end
    if (err_valid && err.whole)
      nxt_st.frz[err.stk] = 1'b1;
    else if (err_valid)
      nxt_st.blk[{err.stk, err.ep}] = 1'b1;

    // lane configuration
    if (cfg_load)
    begin
      nxt_st.cfg_err = !mode_ok(cfg_mode);
      if (mode_ok(cfg_mode))
      begin
        nxt_st.mode = cfg_mode;
        nxt_st.act  = act_of(cfg_mode);
      end
    end
    for (int l = 0; l < phsc_pkg::NLANE; l++)
    begin
      li = 4'(l);
      s  = 2'h0;
      base = 5'h0;
      size = 5'h10;
      if (st_ff.mode != phsc_pkg::MODE_X16)
      begin
        s    = {1'b0, li[3]};
        base = {1'b0, li[3], 3'h0};
        size = 5'h08;
      end
      if (st_ff.mode == phsc_pkg::MODE_X8X4 && li[3])
      begin
        s    = li[2] ? 2'h2 : 2'h1;
        base = {1'b0, li[3:2], 2'h0};
        size = 5'h04;
      end
      nxt_st.lmap[l] = lane_rev[s] ?
        4'(base + base + size - 5'h1 - {1'b0, li}) : li;
    end

    // slowed link logic per stack
    for (int i = 0; i < phsc_pkg::NSTK; i++)
      unique case (link_gen[i])
        2'h0: nxt_st.ldiv[i] = phsc_pkg::DIV_G1;
        2'h1: nxt_st.ldiv[i] = phsc_pkg::DIV_G2;
        2'h2: nxt_st.ldiv[i] = phsc_pkg::DIV_G3;
        2'h3: nxt_st.ldiv[i] = phsc_pkg::DIV_G4;
      endcase

    // control parity
    if (st_ff.prot != ^{st_ff.frz, st_ff.blk, st_ff.mode})
      nxt_st.par_err = 1'b1;
    nxt_st.prot = ^{nxt_st.frz, nxt_st.blk, nxt_st.mode};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_ff         <= '0;
      st_ff.mode    <= MODE_RST;
      st_ff.act     <= act_of(MODE_RST);
      st_ff.prot    <= ^MODE_RST;
      st_ff.ldiv    <= {3{phsc_pkg::DIV_G1}};
      for (int l = 0; l < phsc_pkg::NLANE; l++)
        st_ff.lmap[l] <= 4'(l);
    end
    else
      st_ff <= nxt_st;
  end

  assign fab_valid  = st_ff.fab_v;
  assign fab_req    = st_ff.fab_q;
  assign in_drop    = st_ff.drop;
  assign rsp_valid  = st_ff.rsp_v;
  assign rsp_stk    = st_ff.rsp_stk;
  assign rsp_bad    = st_ff.rsp_bad;
  assign mm_ok      = st_ff.mm_ok;
  assign mm_refuse  = st_ff.mm_ref;
  assign mm_atomic  = st_ff.mm_atom;
  assign frozen     = st_ff.frz;
  assign ep_blocked = st_ff.blk;
  assign par_err    = st_ff.par_err;
  assign stack_act  = st_ff.act;
  assign cfg_err    = st_ff.cfg_err;
  assign lane_map   = st_ff.lmap;
  assign link_div   = st_ff.ldiv;
endmodule

`default_nettype wire

// file: phsc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module phsc_top_chk (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // fabric and completions
  input wire logic                 fab_valid,
  input wire phsc_pkg::phsc_inb_s  fab_req,
  input wire logic                 fab_ready,
  input wire logic                 cpl_valid,
  input wire phsc_pkg::phsc_cpl_s  cpl,
  input wire logic                 rsp_valid,
  input wire logic [1:0]           rsp_stk,
  input wire logic                 rsp_bad,
  // outbound mmio
  input wire logic                 mm_valid,
  input wire phsc_pkg::phsc_mmio_s mm_req,
  input wire logic                 mm_ok,
  input wire logic                 mm_refuse,
  // errors
  input wire logic                 err_valid,
  input wire phsc_pkg::phsc_err_s  err,
  input wire logic [2:0]           stk_reset,
  input wire logic [2:0]           frozen,
  input wire logic [11:0]          ep_blocked,
  // link rate
  input wire logic [2:0][1:0]      link_gen,
  input wire logic [2:0][3:0]      link_div
);
  logic in_win;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // address hits either outbound window
  assign in_win = ((mm_req.addr & phsc_pkg::WIN0_MASK) == phsc_pkg::WIN0_BASE)
               || ((mm_req.addr & phsc_pkg::WIN1_MASK) == phsc_pkg::WIN1_BASE);

  a_rsp_pulse: assert property (
    cpl_valid |=> rsp_valid && rsp_stk == $past(cpl.stk))
    else $error("completion answer missing");
  a_rsp_bad: assert property (
    cpl_valid && cpl.bad |=> rsp_bad)
    else $error("bad completion not marked");
  a_mm_one: assert property (
    mm_valid |=> mm_ok != mm_refuse)
    else $error("mmio answer not exactly one");
  a_mm_window: assert property (
    mm_valid && !mm_req.atomic && !in_win |=> mm_refuse)
    else $error("mmio outside windows accepted");
  a_freeze_set: assert property (
    err_valid && err.whole && err.stk != 2'h3 |=> frozen[$past(err.stk)])
    else $error("stack error did not freeze");
  a_freeze_keep: assert property (
    frozen[0] && !stk_reset[0] |=> frozen[0])
    else $error("freeze dropped without reset");
  a_freeze_iso: assert property (
    err_valid && err.stk == 2'h0 && stk_reset == 3'h0
    |=> frozen[2:1] == $past(frozen[2:1]))
    else $error("freeze leaked to other stack");
  a_ep_block: assert property (
    err_valid && !err.whole && err.stk != 2'h3
    |=> ep_blocked[{$past(err.stk), $past(err.ep)}])
    else $error("endpoint not blocked");
  a_fab_hold: assert property (
    fab_valid && !fab_ready |=> fab_valid && $stable(fab_req))
    else $error("fabric request not held");
  a_div_g1: assert property (
    link_gen[0] == 2'h0 |=> link_div[0] == phsc_pkg::DIV_G1)
    else $error("gen1 divider wrong");
endmodule

bind phsc_top phsc_top_chk u_chk (.core_clk, .rst, .fab_valid, .fab_req,
  .fab_ready, .cpl_valid, .cpl, .rsp_valid, .rsp_stk, .rsp_bad, .mm_valid,
  .mm_req, .mm_ok, .mm_refuse, .err_valid, .err, .stk_reset, .frozen,
  .ep_blocked, .link_gen, .link_div);
`default_nettype wire

// file: phsc_fab_model.sv
`timescale 1ns/1ps
`default_nettype none
module phsc_fab_model (
  // clock and reset
  input wire logic                core_clk,
  input wire logic                rst,
  // fabric requests
  input wire logic                fab_valid,
  input wire phsc_pkg::phsc_inb_s fab_req,
  output logic                    fab_ready,
  // completions
  output logic                    cpl_valid,
  output phsc_pkg::phsc_cpl_s     cpl,
  // slow-down controls
  input wire logic                stall,
  input wire logic                hold
);
  phsc_pkg::phsc_cpl_s pend[$];
  phsc_pkg::phsc_cpl_s c;

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      pend.delete();
      fab_ready <= 1'b0;
      cpl_valid <= 1'b0;
      cpl <= '0;
    end
    else
    begin
      // one completion owed per accepted request
      if (fab_valid && fab_ready)
      begin
        c.stk = fab_req.stk;
        c.rd = (fab_req.kind == phsc_pkg::K_READ);
        c.bad = 1'b0;
        pend.push_back(c);
      end
      fab_ready <= !stall;
      cpl_valid <= 1'b0;
      cpl <= ~cpl;
      if (!hold && pend.size() > 0)
      begin
        cpl_valid <= 1'b1;
        cpl <= pend.pop_front();
      end
    end
  end
endmodule
`default_nettype wire

// file: pcie_host_bridge_stack_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcie_host_bridge_stack_control_tb;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  in_valid = 1'b0;
  phsc_pkg::phsc_inb_s   in_req = '0;
  logic                  in_ready, in_drop, fab_valid, fab_ready;
  phsc_pkg::phsc_inb_s   fab_req;
  logic                  cpl_valid, rsp_valid, rsp_bad;
  phsc_pkg::phsc_cpl_s   cpl;
  logic [1:0]            rsp_stk;
  logic                  mm_valid = 1'b0;
  phsc_pkg::phsc_mmio_s  mm_req = '0;
  logic                  mm_ok, mm_refuse, mm_atomic;
  logic                  mm_done = 1'b0;
  logic                  mm_done_store = 1'b0;
  logic                  err_valid = 1'b0;
  phsc_pkg::phsc_err_s   err = '0;
  logic                  ep_clr_valid = 1'b0;
  logic [3:0]            ep_clr = 4'h0;
  logic [2:0]            stk_reset = 3'h0;
  logic [2:0]            frozen, stack_act;
  logic [11:0]           ep_blocked;
  logic                  par_err, cfg_err;
  logic                  cfg_load = 1'b0;
  phsc_pkg::phsc_mode_e  cfg_mode = phsc_pkg::MODE_X16;
  logic [2:0]            lane_rev = 3'h0;
  logic [2:0][1:0]       link_gen = '0;
  logic [15:0][3:0]      lane_map;
  logic [2:0][3:0]       link_div;
  logic                  stall = 1'b0;
  logic                  hold = 1'b0;
  int                    error_cnt = 0;
  int                    check_count = 0;
  int                    cyc = 0;

  phsc_top #(.CTRL_ID(2)) uut (.core_clk, .rst, .in_valid, .in_req, .in_ready,
    .in_drop, .fab_valid, .fab_req, .fab_ready, .cpl_valid, .cpl, .rsp_valid,
    .rsp_stk, .rsp_bad, .mm_valid, .mm_req, .mm_ok, .mm_refuse, .mm_atomic,
    .mm_done, .mm_done_store, .err_valid, .err, .ep_clr_valid, .ep_clr,
    .stk_reset, .frozen, .ep_blocked, .par_err, .cfg_load, .cfg_mode,
    .lane_rev, .link_gen, .stack_act, .cfg_err, .lane_map, .link_div);
  phsc_fab_model u_fab (.core_clk, .rst, .fab_valid, .fab_req, .fab_ready,
    .cpl_valid, .cpl, .stall, .hold);

  always #2.5 core_clk = ~core_clk;

  task automatic end_of_test;
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one inbound request; d reports a drop
  task automatic send(input logic [1:0] s, input logic [1:0] e,
    input phsc_pkg::phsc_kind_e k, input logic [11:0] m, output logic d);
    int i;
    i = 0;
    d = 1'b0;
    in_valid <= 1'b1;
    in_req <= '{s, e, k, m, 8'h5A};
    do @(posedge core_clk); while (!in_ready && ++i < 30);
    in_valid <= 1'b0;
    repeat (5)
    begin
      @(posedge core_clk);
      d |= in_drop;
    end
  endtask

  task automatic mm(input logic [31:0] a, input logic st, input logic at,
    input logic [1:0] s, output logic [2:0] r);
    mm_valid <= 1'b1;
    mm_req <= '{a, s, st, at};
    @(posedge core_clk);
    mm_valid <= 1'b0;
    @(posedge core_clk);
    r = {mm_atomic, mm_ok, mm_refuse};
  endtask

  task automatic cfg(input logic [1:0] m, output logic [2:0] act);
    cfg_mode <= phsc_pkg::phsc_mode_e'(m);
    cfg_load <= 1'b1;
    @(posedge core_clk);
    cfg_load <= 1'b0;
    step(3);
    act = stack_act;
  endtask

  task automatic pulse_err(input logic [1:0] s, input logic [1:0] e,
    input logic w);
    err_valid <= 1'b1;
    err <= '{s, e, w};
    @(posedge core_clk);
    err_valid <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic t_reset;
    int i;
    @(posedge core_clk);
    chk({frozen, ep_blocked, par_err, in_ready}, 17'h1);
    chk(stack_act, 3'b001);
    for (i = 0; i < 16; i++)
      chk(lane_map[i], i);
    chk(link_div, 12'h888);
  endtask

  task automatic t_cfg;
    logic [2:0] a;
    logic d;
    int g;
    send(2'h1, 2'h0, phsc_pkg::K_READ, 12'h000, d);
    chk(d, 1'b1);
    cfg(2'h1, a);
    chk(a, 3'b011);
    cfg(2'h3, a);
    chk({cfg_err, a}, 4'b1011);
    lane_rev <= 3'b010;
    cfg(2'h2, a);
    chk({cfg_err, a}, 4'b0111);
    chk({lane_map[8], lane_map[11], lane_map[0]}, 12'hB80);
    for (g = 0; g < 4; g++)
    begin
      link_gen <= {3{g[1:0]}};
      step(3);
      chk(link_div[2], 4'h8 >> g);
    end
  endtask

  task automatic t_msi;
    logic d;
    send(2'h1, 2'h0, phsc_pkg::K_MSI, 12'h800, d);
    chk(d, 1'b1);
    send(2'h1, 2'h0, phsc_pkg::K_MSI, 12'h7FF, d);
    chk(d, 1'b0);
    send(2'h0, 2'h0, phsc_pkg::K_MSI, 12'hFFF, d);
    chk(d, 1'b0);
  endtask

  task automatic t_ep;
    logic d;
    pulse_err(2'h0, 2'h1, 1'b0);
    chk(ep_blocked, 12'h002);
    send(2'h0, 2'h1, phsc_pkg::K_WRITE, 12'h000, d);
    chk(d, 1'b1);
    send(2'h0, 2'h2, phsc_pkg::K_WRITE, 12'h000, d);
    chk(d, 1'b0);
    send(2'h2, 2'h0, phsc_pkg::K_ATOM, 12'h000, d);
    chk(d, 1'b0);
    ep_clr_valid <= 1'b1;
    ep_clr <= 4'h1;
    @(posedge core_clk);
    ep_clr_valid <= 1'b0;
    step(2);
    chk(ep_blocked, 12'h000);
  endtask

  task automatic t_freeze;
    logic d;
    logic [2:0] r;
    int i;
    hold <= 1'b1;
    send(2'h0, 2'h2, phsc_pkg::K_READ, 12'h000, d);
    pulse_err(2'h0, 2'h0, 1'b1);
    chk(frozen, 3'b001);
    hold <= 1'b0;
    i = 0;
    do @(posedge core_clk); while (!rsp_valid && ++i < 10);
    chk({rsp_valid, rsp_bad, rsp_stk}, 4'b1100);
    send(2'h0, 2'h0, phsc_pkg::K_READ, 12'h000, d);
    chk(d, 1'b1);
    send(2'h1, 2'h0, phsc_pkg::K_WRITE, 12'h000, d);
    chk(d, 1'b0);
    mm(32'h8000_0000, 1'b1, 1'b0, 2'h0, r);
    chk(r, 3'b001);
    step(50);
    chk(frozen, 3'b001);
    stk_reset <= 3'b001;
    @(posedge core_clk);
    stk_reset <= 3'b000;
    step(2);
    chk(frozen, 3'b000);
  endtask

  task automatic t_mmio;
    logic [2:0] r;
    int i;
    mm(32'h8000_0000, 1'b1, 1'b0, 2'h1, r);
    chk(r, 3'b010);
    mm(32'hAFFF_FFF0, 1'b0, 1'b0, 2'h1, r);
    chk(r, 3'b010);
    mm(32'h9000_0000, 1'b1, 1'b0, 2'h1, r);
    chk(r, 3'b001);
    mm(32'h1000_0000, 1'b1, 1'b1, 2'h1, r);
    chk(r, 3'b110);
    for (i = 0; i < 15; i++)
    begin
      mm(32'h8000_0100, 1'b1, 1'b0, 2'h2, r);
      chk(r, (i < 14) ? 3'b010 : 3'b001);
    end
    for (i = 0; i < 16; i++)
    begin
      mm(32'hA000_0100, 1'b0, 1'b0, 2'h2, r);
      chk(r, (i < 15) ? 3'b010 : 3'b001);
    end
    mm_done <= 1'b1;
    mm_done_store <= 1'b1;
    @(posedge core_clk);
    mm_done <= 1'b0;
    step(1);
    mm(32'h8000_0100, 1'b1, 1'b0, 2'h2, r);
    chk(r, 3'b010);
  endtask

  task automatic t_fill;
    int n;
    int m;
    n = 0;
    m = 0;
    stall <= 1'b1;
    step(2);
    in_valid <= 1'b1;
    in_req <= '{2'h0, 2'h3, phsc_pkg::K_WRITE, 12'h000, 8'h11};
    repeat (15)
    begin
      @(posedge core_clk);
      n += in_ready;
    end
    chk(in_ready, 1'b0);
    in_valid <= 1'b0;
    stall <= 1'b0;
    repeat (40)
    begin
      @(posedge core_clk);
      m += fab_valid && fab_ready;
      if (fab_valid && fab_ready)
        chk({fab_req.ep, fab_req.tag}, 10'h311);
    end
    chk(m, n);
    chk(in_ready, 1'b1);
    chk(par_err, 1'b0);
  endtask

  task automatic t_credit(input phsc_pkg::phsc_kind_e k, input int lim);
    int n;
    int m;
    n = 0;
    m = 0;
    hold <= 1'b1;
    in_valid <= 1'b1;
    in_req <= '{2'h1, 2'h1, k, 12'h000, 8'h22};
    repeat (lim + 8)
    begin
      @(posedge core_clk);
      n += in_ready;
      m += fab_valid && fab_ready;
    end
    in_valid <= 1'b0;
    repeat (20)
    begin
      @(posedge core_clk);
      m += fab_valid && fab_ready;
    end
    chk(n, lim + 8);
    chk(m, lim);
    hold <= 1'b0;
    step(lim + 40);
    chk(in_ready, 1'b1);
  endtask

  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_of_test;
    end
  end

  initial
  begin
    step(12);
    rst <= 1'b0;
    t_reset;
    t_cfg;
    t_msi;
    t_ep;
    t_freeze;
    t_mmio;
    t_fill;
    t_credit(phsc_pkg::K_WRITE, phsc_pkg::WR_MAX);
    t_credit(phsc_pkg::K_READ, phsc_pkg::RD_MAX);
    end_of_test;
  end
endmodule
`default_nettype wire
